/* File: shr_pkg.sv */
package shr_pkg;

   // ==========================================================
   // Sizes
   localparam int SHR_NUM_STATES = 63;
   localparam int SHR_PDO_W = 10;
   localparam int SHR_IDX_W = 6;
   localparam int SHR_SUP_W = 8;
   localparam int SHR_CNT_W = 25;

   // ==========================================================
   // Register map
   localparam logic [7:0] SHR_ADDR_ENTRY_OUT = 8'h80;
   localparam logic [7:0] SHR_ADDR_ENTRY_CTRL = 8'h81;
   localparam logic [7:0] SHR_ADDR_ENTRY_TGT = 8'h82;
   localparam logic [7:0] SHR_ADDR_ENTRY_FLT = 8'h83;
   localparam logic [7:0] SHR_ADDR_PROG_INDEX = 8'h90;
   localparam logic [7:0] SHR_ADDR_SEQ_CTRL = 8'h93;
   localparam logic [7:0] SHR_ADDR_CUR_STATE = 8'h94;
   localparam logic [7:0] SHR_ADDR_FAULT_STAT = 8'h95;
   localparam logic [7:0] SHR_ADDR_SUPPLY_STAT = 8'h96;
   localparam logic [7:0] SHR_UNMAPPED_DATA = 8'h00;

   // Sequencer control fields
   localparam int SHR_CTRL_ENABLE_BIT = 0;
   localparam int SHR_CTRL_HALTED_BIT = 1;
   localparam int SHR_CTRL_RESUME_BIT = 2;

   // Entry control byte fields
   localparam int SHR_F_OUTHI_LSB = 0;
   localparam int SHR_F_COND_LSB = 2;
   localparam int SHR_F_DLY_LSB = 4;
   localparam logic [SHR_IDX_W-1:0] SHR_START_STATE = 6'h00;

   // ==========================================================
   // Timing
   localparam int SHR_CLK_KHZ = 250000;
   localparam int SHR_T1_MS = 1;
   localparam int SHR_T10_MS = 10;
   localparam int SHR_T100_MS = 100;

   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      SHR_COND_DELAY = 2'h0,
      SHR_COND_RESUME = 2'h1,
      SHR_COND_MONITOR = 2'h2,
      SHR_COND_HOLD = 2'h3
   } shr_cond_t;

   typedef enum logic [1:0]
   {
      SHR_DLY_NONE = 2'h0,
      SHR_DLY_1MS = 2'h1,
      SHR_DLY_10MS = 2'h2,
      SHR_DLY_100MS = 2'h3
   } shr_dly_t;

   typedef enum logic [1:0]
   {
      SHR_ENG_OFF,
      SHR_ENG_STEP,
      SHR_ENG_DELAY
   } shr_eng_t;

   typedef struct packed
   {
      logic [SHR_PDO_W-1:0] outputs;
      shr_cond_t cond;
      shr_dly_t dly;
      logic [SHR_IDX_W-1:0] target;
      logic [SHR_IDX_W-1:0] fault_target;
   } shr_entry_t;

endpackage

/* File: shr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module shr_timer
(
   // Clock and control
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Start with a cycle count
   input wire logic start_in,
   input wire logic [shr_pkg::SHR_CNT_W-1:0] load_in,
   // Expiry pulse
   output logic done_out
);
   import shr_pkg::*;

   typedef struct packed
   {
      logic [SHR_CNT_W-1:0] cnt;
      logic busy;
      logic done;
   } shr_tmr_t;

   shr_tmr_t st_reg;
   shr_tmr_t st_next;

   // Countdown; a fresh start restarts the count
   always_comb
   begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start_in)
      begin
         st_next.cnt = load_in - 1'b1;
         st_next.busy = 1'b1;
      end
      else if (st_reg.busy)
      begin
         if (st_reg.cnt == '0)
         begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end
         else
         begin
            st_next.cnt = st_reg.cnt - 1'b1;
         end
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         st_reg <= '0;
      else if (ce_in)
         st_reg <= st_next;
   end

   assign done_out = st_reg.done;

endmodule
`default_nettype wire

/* File: shr_sequencer.sv */
// Operation
// - Engine holds 63 programmable states with outputs
// - Any state may use the resume condition
// - Resume state halts until resume bit set
// - Resume bit self-clears after the transition
// - Resume bit is bit 2 at 0x93
// - Monitor state jumps to fault target on fault
// - Each state drives its programmed output levels
// - Clear-interrupt state releases the interrupt output
// - Exit goes to target after programmed delay
// - Fault status readable while halted
`timescale 1ns/1ps
`default_nettype none
module shr_sequencer
#(
   parameter int DLY_1MS_CYC = shr_pkg::SHR_T1_MS * shr_pkg::SHR_CLK_KHZ,
   parameter int DLY_10MS_CYC = shr_pkg::SHR_T10_MS * shr_pkg::SHR_CLK_KHZ,
   parameter int DLY_100MS_CYC = shr_pkg::SHR_T100_MS * shr_pkg::SHR_CLK_KHZ
)
(
   // Clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Register port from the serial front end
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // Supply monitor, high when in tolerance
   input wire logic [shr_pkg::SHR_SUP_W-1:0] supply_ok_in,
   // Sequencer outputs
   output logic [shr_pkg::SHR_PDO_W-1:0] pdo_out,
   output logic [shr_pkg::SHR_IDX_W-1:0] state_out,
   output logic halted_out
);
   import shr_pkg::*;
   typedef struct packed
   {
      shr_entry_t [SHR_NUM_STATES-1:0] prog;
      logic [SHR_IDX_W-1:0] index;
      logic enable;
      logic resume;
      logic halted;
      shr_eng_t eng;
      logic [SHR_IDX_W-1:0] cur;
      logic [SHR_IDX_W-1:0] dest;
      logic [SHR_PDO_W-1:0] programmable_drive_output;
      logic [SHR_SUP_W-1:0] fault;
      logic [7:0] rdata;
      logic tmr_start;
      logic [SHR_CNT_W-1:0] tmr_load;
   } shr_core_t;
   shr_core_t st_reg;
   shr_core_t st_next;
   shr_entry_t cur_entry;
   logic tmr_done;
   logic exit_resume;
   logic wr_resume;
   logic supply_bad;
   // ==========================================================
   // Helpers
   // Send a state number past the programmed range to the start state
   function automatic logic [SHR_IDX_W-1:0] idx_fix(
      input logic [SHR_IDX_W-1:0] idx);
      if (idx >= SHR_IDX_W'(SHR_NUM_STATES))
         return SHR_START_STATE;
      return idx;
   endfunction
   // Delay selection to cycle count
   function automatic logic [SHR_CNT_W-1:0] dly_count(input shr_dly_t d);
      case (d)
         SHR_DLY_1MS: return SHR_CNT_W'(DLY_1MS_CYC);
         SHR_DLY_10MS: return SHR_CNT_W'(DLY_10MS_CYC);
         SHR_DLY_100MS: return SHR_CNT_W'(DLY_100MS_CYC);
         default: return SHR_CNT_W'(1);
      endcase
   endfunction
   // Current entry and fault summary
   assign cur_entry = st_reg.prog[st_reg.cur];
   assign supply_bad = |(~supply_ok_in);
   assign wr_resume = reg_wr_in && (reg_addr_in == SHR_ADDR_SEQ_CTRL) &&
      reg_wdata_in[SHR_CTRL_RESUME_BIT];
   // ==========================================================
   // Delay timer
   shr_timer u_timer
   (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .start_in(st_reg.tmr_start),
      .load_in(st_reg.tmr_load),
      .done_out(tmr_done)
   );
   // ==========================================================
   // Next-state logic
   always_comb
   begin
      st_next = st_reg;
      st_next.tmr_start = 1'b0;
      exit_resume = 1'b0;
      // Register writes
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            SHR_ADDR_ENTRY_OUT:
               st_next.prog[st_reg.index].outputs[7:0] = reg_wdata_in;
            SHR_ADDR_ENTRY_CTRL:
            begin
               st_next.prog[st_reg.index].outputs[SHR_PDO_W-1:8] =
                  reg_wdata_in[SHR_F_OUTHI_LSB+:2];
               st_next.prog[st_reg.index].cond =
                  shr_cond_t'(reg_wdata_in[SHR_F_COND_LSB+:2]);
               st_next.prog[st_reg.index].dly =
                  shr_dly_t'(reg_wdata_in[SHR_F_DLY_LSB+:2]);
            end
            SHR_ADDR_ENTRY_TGT:
               st_next.prog[st_reg.index].target =
                  idx_fix(reg_wdata_in[SHR_IDX_W-1:0]);
            SHR_ADDR_ENTRY_FLT:
               st_next.prog[st_reg.index].fault_target =
                  idx_fix(reg_wdata_in[SHR_IDX_W-1:0]);
            SHR_ADDR_PROG_INDEX:
               st_next.index = idx_fix(reg_wdata_in[SHR_IDX_W-1:0]);
            SHR_ADDR_SEQ_CTRL:
               st_next.enable = reg_wdata_in[SHR_CTRL_ENABLE_BIT];
            default: st_next.index = st_reg.index;
         endcase
      end
      // Sequencing engine
      if (!st_reg.enable)
         st_next.eng = SHR_ENG_OFF;
      else
      begin
         case (st_reg.eng)
            SHR_ENG_OFF:
            begin
               st_next.cur = SHR_START_STATE;
               st_next.eng = SHR_ENG_STEP;
            end
            SHR_ENG_STEP:
            begin
               case (cur_entry.cond)
                  SHR_COND_DELAY, SHR_COND_RESUME:
                  begin
                     // Resume state waits here for the bit
                     if (cur_entry.cond == SHR_COND_DELAY ||
                        st_reg.resume)
                     begin
                        if (cur_entry.dly == SHR_DLY_NONE)
                        begin
                           st_next.cur = cur_entry.target;
                           exit_resume = st_reg.resume &&
                              (cur_entry.cond == SHR_COND_RESUME);
                        end
                        else
                        begin
                           st_next.dest = cur_entry.target;
                           st_next.tmr_start = 1'b1;
                           st_next.tmr_load = dly_count(cur_entry.dly);
                           st_next.eng = SHR_ENG_DELAY;
                        end
                     end
                  end
                  SHR_COND_MONITOR:
                     if (supply_bad)
                        st_next.cur = cur_entry.fault_target;
                  default:
                     st_next.cur = st_reg.cur;
               endcase
            end
            SHR_ENG_DELAY:
               if (tmr_done)
               begin
                  st_next.cur = st_reg.dest;
                  st_next.eng = SHR_ENG_STEP;
                  exit_resume = (cur_entry.cond == SHR_COND_RESUME);
               end
            default:
               st_next.eng = SHR_ENG_OFF;
         endcase
         // Outputs follow the current state, also while halted
         st_next.programmable_drive_output = cur_entry.outputs;
      end
      // Resume bit: clears on the transition, a new set wins
      if (exit_resume)
         st_next.resume = 1'b0;
      if (wr_resume)
         st_next.resume = 1'b1;
      // Sticky fault flags: write 1 clears, new faults win
      if (reg_wr_in && reg_addr_in == SHR_ADDR_FAULT_STAT)
         st_next.fault = st_reg.fault & ~reg_wdata_in;
      if (st_reg.enable && st_reg.eng == SHR_ENG_STEP &&
         cur_entry.cond == SHR_COND_MONITOR && supply_bad)
         st_next.fault = st_next.fault | ~supply_ok_in;
      st_next.halted = (st_next.eng == SHR_ENG_STEP) &&
         (st_next.prog[st_next.cur].cond == SHR_COND_RESUME) &&
         !st_next.resume;
      // Register reads
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            SHR_ADDR_ENTRY_OUT:
               st_next.rdata = st_reg.prog[st_reg.index].outputs[7:0];
            SHR_ADDR_ENTRY_CTRL:
               st_next.rdata = {2'h0, st_reg.prog[st_reg.index].dly,
                  st_reg.prog[st_reg.index].cond,
                  st_reg.prog[st_reg.index].outputs[SHR_PDO_W-1:8]};
            SHR_ADDR_ENTRY_TGT:
               st_next.rdata = {2'h0, st_reg.prog[st_reg.index].target};
            SHR_ADDR_ENTRY_FLT:
               st_next.rdata = {2'h0,
                  st_reg.prog[st_reg.index].fault_target};
            SHR_ADDR_PROG_INDEX: st_next.rdata = {2'h0, st_reg.index};
            SHR_ADDR_SEQ_CTRL:
               st_next.rdata = {5'h00, st_reg.resume, st_reg.halted,
                  st_reg.enable};
            SHR_ADDR_CUR_STATE: st_next.rdata = {2'h0, st_reg.cur};
            SHR_ADDR_FAULT_STAT: st_next.rdata = st_reg.fault;
            SHR_ADDR_SUPPLY_STAT: st_next.rdata = supply_ok_in;
            default: st_next.rdata = SHR_UNMAPPED_DATA;
         endcase
      end
   end
   // State register, frozen while ce is low
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         st_reg <= '0;
      else if (ce_in)
         st_reg <= st_next;
   end
   // Outputs straight from the state register
   assign pdo_out = st_reg.programmable_drive_output;
   assign state_out = st_reg.cur;
   assign halted_out = st_reg.halted;
   assign reg_rdata_out = st_reg.rdata;
   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence resume_go_s;
      ce_in && st_reg.enable && st_reg.eng == SHR_ENG_STEP &&
         cur_entry.cond == SHR_COND_RESUME && st_reg.resume &&
         cur_entry.dly != SHR_DLY_NONE;
   endsequence
   sequence delay_armed_s;
      st_reg.eng == SHR_ENG_DELAY && st_reg.tmr_start;
   endsequence
   // Outputs lag the state by one cycle, so skip the entry cycle
   sequence halt_quiet_s;
      ce_in && halted_out && !reg_wr_in ##1 ce_in && halted_out ##1
         ce_in && halted_out;
   endsequence
   state_range_a: assert property (
      st_reg.cur < SHR_IDX_W'(SHR_NUM_STATES))
      else $error("current state out of range");
   cond_program_a: assert property (
      ce_in && reg_wr_in && reg_addr_in == SHR_ADDR_ENTRY_CTRL |=>
      st_reg.prog[$past(st_reg.index)].cond ==
      $past(reg_wdata_in[SHR_F_COND_LSB+:2]))
      else $error("condition field not stored");
   resume_halt_a: assert property (
      st_reg.eng == SHR_ENG_STEP && cur_entry.cond == SHR_COND_RESUME &&
      !st_reg.resume |=> st_reg.cur == $past(st_reg.cur))
      else $error("engine left a halted state");
   resume_clear_a: assert property (
      ce_in && exit_resume && !wr_resume |=> !st_reg.resume)
      else $error("resume bit did not self-clear");
   resume_set_a: assert property (
      ce_in && wr_resume |=> st_reg.resume && !halted_out)
      else $error("resume bit not set by write");
   monitor_fault_a: assert property (
      ce_in && st_reg.enable && st_reg.eng == SHR_ENG_STEP &&
      cur_entry.cond == SHR_COND_MONITOR && supply_bad |=>
      st_reg.cur == $past(cur_entry.fault_target))
      else $error("fault did not reach fault target");
   pdo_follow_a: assert property (
      ce_in && st_reg.enable |=> pdo_out == $past(cur_entry.outputs))
      else $error("outputs do not follow state");
   resume_delay_a: assert property (
      resume_go_s |=> delay_armed_s ##0
      st_reg.dest == $past(cur_entry.target))
      else $error("resume did not arm the delay");
   delay_expire_a: assert property (
      ce_in && st_reg.enable && st_reg.eng == SHR_ENG_DELAY && tmr_done |=>
      st_reg.cur == $past(st_reg.dest) && st_reg.eng == SHR_ENG_STEP)
      else $error("delay expiry missed the target");
   fault_read_a: assert property (
      ce_in && reg_rd_in && reg_addr_in == SHR_ADDR_FAULT_STAT |=>
      reg_rdata_out == $past(st_reg.fault))
      else $error("fault status read wrong");
   halted_hold_a: assert property (
      halt_quiet_s |-> $stable(pdo_out))
      else $error("outputs moved while halted");
endmodule
`default_nettype wire

/* File: shr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module shr_host_model
   import shr_pkg::*;
(
   // Clock
   input wire logic mclk_in,
   // Register port toward the sequencer
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out,
   // Interrupt line from an output pin, low when raised
   input wire logic irq_in
);
   // ==========================================================
   // Idle bus at time zero
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 8'h00;
   end

   // One write, held up to its taking edge
   task automatic write(input logic [7:0] a, input logic [7:0] d);
   begin
      @(posedge mclk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge mclk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a; // Released bus shows no stale value
      reg_wdata_out <= ~d;
   end
   endtask

   // One read strobe; data is checked by the bench monitor
   task automatic read(input logic [7:0] a);
   begin
      @(posedge mclk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge mclk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
   end
   endtask

   // Release a halted engine, engine left enabled
   task automatic resume();
   begin
      write(SHR_ADDR_SEQ_CTRL, 8'h05);
   end
   endtask

   // Wait a bounded time for the interrupt line to fall
   task automatic wait_irq(input int lim, output logic seen);
   begin
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++)
      begin
         @(posedge mclk_in);
         seen = (irq_in === 1'b0);
      end
   end
   endtask
endmodule
`default_nettype wire

/* File: sequencer_halt_resume_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sequencer_halt_resume_tb;
   import shr_pkg::*;
   // ==========================================================
   // Signals
   logic mclk_in, rst_n_in, ce_in, rd_pend, seen;
   logic [7:0] supply_ok_in, mask;
   wire logic [7:0] reg_addr_in, reg_wdata_in;
   wire logic reg_wr_in, reg_rd_in;
   logic [7:0] reg_rdata_out;
   logic [9:0] pdo_out, out3;
   logic [5:0] state_out;
   logic halted_out;
   logic [7:0] exp_q[$];
   int errors, checked, cycles, cnt;

   // ==========================================================
   // Design and host
   shr_sequencer #(.DLY_1MS_CYC(4), .DLY_10MS_CYC(8),
      .DLY_100MS_CYC(16)) dut_u (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .supply_ok_in(supply_ok_in), .pdo_out(pdo_out),
      .state_out(state_out), .halted_out(halted_out));
   shr_host_model host_u (.mclk_in(mclk_in), .reg_addr_out(reg_addr_in),
      .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
      .reg_wdata_out(reg_wdata_in), .irq_in(pdo_out[0]));

   // Clock
   initial
   begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end

   // ==========================================================
   // Compare and report
   task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t read got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task automatic check_port(input logic [15:0] got, input logic [15:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t port got %h exp %h", $time, got, exp);
      end
   end
   endtask

   task automatic summarize();
   begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask

   // Read data monitor, oldest note first
   always @(posedge mclk_in)
   begin
      if (rd_pend && exp_q.size() > 0)
         check_read(reg_rdata_out, exp_q.pop_front());
      rd_pend <= reg_rd_in & ce_in;
   end

   // Hang guard
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         summarize();
      end
   end

   // ==========================================================
   // Helpers
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
   begin
      exp_q.push_back(exp);
      host_u.read(a);
   end
   endtask

   task automatic prog(input logic [5:0] idx, input logic [9:0] o,
      input shr_cond_t c, input shr_dly_t d, input logic [5:0] t,
      input logic [5:0] f);
   begin
      host_u.write(SHR_ADDR_PROG_INDEX, {2'b00, idx});
      host_u.write(SHR_ADDR_ENTRY_OUT, o[7:0]);
      host_u.write(SHR_ADDR_ENTRY_CTRL, {2'b00, d, c, o[9:8]});
      host_u.write(SHR_ADDR_ENTRY_TGT, {2'b00, t});
      host_u.write(SHR_ADDR_ENTRY_FLT, {2'b00, f});
   end
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      supply_ok_in = 8'hff;
      void'($urandom(73859));
      mask = 8'($urandom_range(255, 1));
      out3 = 10'($urandom_range(1023, 2));
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      rd(SHR_ADDR_SEQ_CTRL, 8'h00);
      rd(8'h10, SHR_UNMAPPED_DATA);
      host_u.write(SHR_ADDR_PROG_INDEX, 8'h3e);
      rd(SHR_ADDR_PROG_INDEX, 8'h3e);
      host_u.write(SHR_ADDR_PROG_INDEX, 8'h3f);
      rd(SHR_ADDR_PROG_INDEX, 8'h00);
      // Good, fault, clear-interrupt and final states
      prog(6'h00, 10'h001, SHR_COND_MONITOR, SHR_DLY_NONE, 6'h00, 6'h01);
      prog(6'h01, 10'h000, SHR_COND_RESUME, SHR_DLY_100MS, 6'h02, 6'h00);
      prog(6'h02, 10'h001, SHR_COND_RESUME, SHR_DLY_NONE, 6'h03, 6'h00);
      prog(6'h03, out3, SHR_COND_HOLD, SHR_DLY_NONE, 6'h00, 6'h00);
      host_u.write(SHR_ADDR_SEQ_CTRL, 8'h01);
      repeat (4) @(posedge mclk_in);
      check_port(16'(state_out), 16'h0000);
      check_port(16'(pdo_out), 16'h0001);
      // Supply fault raises the interrupt and halts
      supply_ok_in <= ~mask;
      host_u.wait_irq(10, seen);
      check_port(16'(seen), 16'h0001);
      repeat (2) @(posedge mclk_in);
      check_port(16'(state_out), 16'h0001);
      check_port(16'(halted_out), 16'h0001);
      rd(SHR_ADDR_FAULT_STAT, mask);
      rd(SHR_ADDR_SEQ_CTRL, 8'h03);
      supply_ok_in <= 8'hff;
      repeat (40) @(posedge mclk_in);
      check_port(16'(state_out), 16'h0001);
      check_port(16'(pdo_out), 16'h0000);
      host_u.write(SHR_ADDR_SEQ_CTRL, 8'h01);
      repeat (5) @(posedge mclk_in);
      check_port(16'(halted_out), 16'h0001);
      // A resume write while ce is low must be lost
      ce_in <= 1'b0;
      host_u.resume();
      ce_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      check_port(16'(halted_out), 16'h0001);
      // Resume then programmed delay
      host_u.resume();
      cnt = 0;
      while (state_out !== 6'h02 && cnt < 100)
      begin
         @(posedge mclk_in);
         cnt++;
      end
      check_port(16'(cnt >= 16 && cnt <= 24), 16'h0001);
      repeat (2) @(posedge mclk_in);
      check_port(16'(pdo_out), 16'h0001);
      rd(SHR_ADDR_SEQ_CTRL, 8'h03);
      // Second resume state with no delay
      host_u.resume();
      repeat (3) @(posedge mclk_in);
      check_port(16'(state_out), 16'h0003);
      @(posedge mclk_in);
      check_port(16'(pdo_out), 16'(out3));
      rd(SHR_ADDR_SEQ_CTRL, 8'h01);
      repeat (4) @(posedge mclk_in);
      summarize();
   end
endmodule
`default_nettype wire
